// ---- design/lwfm_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module lwfm_top
   import lwfm_pkg::*;
#(
   parameter int WU_MIN     = WU_MIN_CYC,
   parameter int WU_MAX     = WU_MAX_CYC,
   parameter int SHORT_LONG = SHORT_CYC,
   parameter int WAKE_HOLD  = WAKE_HOLD_CYC
) (
   input  wire logic        hclk,          // 200 MHz system clock
   input  wire logic        hresetn,       // async reset, low
   input  wire logic        hsel,          // slave select
   input  wire logic [31:0] haddr,         // byte address
   input  wire logic [1:0]  htrans,        // transfer type
   input  wire logic        hwrite,        // write when high
   input  wire logic [2:0]  hsize,         // transfer size
   input  wire logic [31:0] hwdata,        // write data
   input  wire logic        hready,        // bus ready in
   output logic             hreadyout,     // always ready
   output logic             hresp,         // always okay
   output logic [31:0]      hrdata,        // read data
   input  wire logic        en_pin_i,      // driver enable
   input  wire logic        tx_pin_i,      // transmit level
   input  wire logic        line_pin_i,    // sensed line level
   output logic             line_pin_o,    // line drive level
   output logic             line_pin_oe,   // line driven
   output logic             ls_on_o,       // low-side switch on
   output logic             hs_on_o,       // high-side switch on
   input  wire logic        cur_limit_i,   // current limit active
   input  wire logic        over_temp_i,   // over-temperature
   output logic             rx_o,          // received level
   output logic             wake_o,        // open-drain level
   output logic             wake_oe,       // wake indicator pull
   output logic             short_flag_o,  // open-drain level
   output logic             short_flag_oe, // short flag pull
   output logic             irq_o          // level interrupt
);
   localparam logic [CNT_W-1:0] HOLD_C = CNT_W'(WAKE_HOLD);

   // ----------------------------------------------------------------
   // input synchronisers: three stages, change accepted on agreement
   // ----------------------------------------------------------------
   logic [NSYNC-1:0] pin_in;
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   logic [NSYNC-1:0] s3_q;
   logic [NSYNC-1:0] filt_q;

   assign pin_in = {over_temp_i, cur_limit_i, line_pin_i,
                    tx_pin_i, en_pin_i};

   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            s1_q[i]   <= 1'b0;
            s2_q[i]   <= 1'b0;
            s3_q[i]   <= 1'b0;
            filt_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= pin_in[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               filt_q[i] <= s3_q[i];
            end
         end
      end
   end

   logic en_f;
   logic tx_f;
   logic line_f;
   logic cur_f;
   logic ot_f;
   assign en_f   = filt_q[IN_EN];
   assign tx_f   = filt_q[IN_TX];
   assign line_f = filt_q[IN_LINE];
   assign cur_f  = filt_q[IN_CUR];
   assign ot_f   = filt_q[IN_OT];

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [1:0]       ctrl_q;
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] stat_d;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   // ----------------------------------------------------------------
   // driver decode
   // ----------------------------------------------------------------
   logic drv_on;
   assign drv_on = en_f && !ot_f && !ctrl_q[CTRL_DRV_OFF];

   // tx held high with enable toggled gives plain low-side switching
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ls_on_o     <= 1'b0;
         hs_on_o     <= 1'b0;
         line_pin_o  <= 1'b0;
         line_pin_oe <= 1'b0;
      end else begin
         ls_on_o     <= drv_on && tx_f;
         hs_on_o     <= drv_on && !tx_f;
         line_pin_o  <= drv_on && !tx_f;
         line_pin_oe <= drv_on;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_o <= 1'b0;
      end else begin
         rx_o <= line_f;
      end
   end

   // ----------------------------------------------------------------
   // wake and short detection
   // ----------------------------------------------------------------
   lwfm_det_if det ();

   assign det.cond = cur_f;

   lwfm_pulse_timer #(
      .WIN_MIN (WU_MIN),
      .WIN_MAX (WU_MAX),
      .LONG    (SHORT_LONG)
   ) u_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .det     (det)
   );

   logic             wake_q;
   logic [CNT_W-1:0] wake_cnt_q;
   logic             wake_hit;
   assign wake_hit = det.hit && ctrl_q[CTRL_WAKE_EN];

   // indicator held for a fixed time so a slow controller sees it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_q     <= 1'b0;
         wake_cnt_q <= '0;
      end else if (wake_hit) begin
         wake_q     <= 1'b1;
         wake_cnt_q <= HOLD_C;
      end else if (wake_cnt_q > 1) begin
         wake_cnt_q <= wake_cnt_q - 1'b1;
      end else begin
         wake_q     <= 1'b0;
         wake_cnt_q <= '0;
      end
   end

   logic short_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         short_q <= 1'b0;
      end else begin
         short_q <= det.long_q && cur_f;
      end
   end

   assign wake_o        = 1'b0;
   assign wake_oe       = wake_q;
   assign short_flag_o  = 1'b0;
   assign short_flag_oe = short_q;

   // ----------------------------------------------------------------
   // interrupt events
   // ----------------------------------------------------------------
   logic short_d1_q;
   logic ot_d1_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         short_d1_q <= 1'b0;
         ot_d1_q    <= 1'b0;
      end else begin
         short_d1_q <= short_q;
         ot_d1_q    <= ot_f;
      end
   end

   always_comb begin
      irq_set             = '0;
      irq_set[IRQ_WAKE]   = wake_hit;
      irq_set[IRQ_SHORT]  = short_q && !short_d1_q;
      irq_set[IRQ_OT_SET] = ot_f && !ot_d1_q;
      irq_set[IRQ_OT_CLR] = !ot_f && ot_d1_q;
   end

   // ----------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ----------------------------------------------------------------
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;
   logic       acc;
   logic [7:0] a_ofs;
   assign acc   = hsel && htrans[1] && hready;
   assign a_ofs = haddr[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         wr_pend_q <= acc && hwrite && haddr[31:8] == 24'h000000;
         wr_addr_q <= a_ofs;
      end
   end

   // read data captured in the address phase, stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (acc && !hwrite) begin
         if (haddr[31:8] != 24'h000000) begin
            hrdata <= '0;
         end else if (a_ofs == OFS_CTRL) begin
            hrdata <= {30'h00000000, ctrl_q};
         end else if (a_ofs == OFS_STATUS) begin
            hrdata <= {25'h0000000, ot_f, cur_f, line_f, tx_f, en_f,
                       short_q, wake_q};
         end else if (a_ofs == OFS_IRQ_STAT) begin
            hrdata <= {28'h0000000, stat_q};
         end else if (a_ofs == OFS_IRQ_MASK) begin
            hrdata <= {28'h0000000, mask_q};
         end else begin
            hrdata <= '0;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= CTRL_RST;
         mask_q <= IRQ_MASK_RST;
      end else if (wr_pend_q) begin
         if (wr_addr_q == OFS_CTRL) begin
            ctrl_q <= hwdata[1:0];
         end else if (wr_addr_q == OFS_IRQ_MASK) begin
            mask_q <= hwdata[IRQ_W-1:0];
         end
      end
   end

   // set wins over a write-one clear in the same cycle
   assign irq_clr = (wr_pend_q && wr_addr_q == OFS_IRQ_STAT)
                    ? hwdata[IRQ_W-1:0] : '0;
   assign stat_d  = (stat_q & ~irq_clr) | irq_set;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= '0;
         irq_o  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         irq_o  <= |(stat_d & mask_q);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_float;
      @(posedge hclk) disable iff (!hresetn)
      !en_f |=> !line_pin_oe && !ls_on_o && !hs_on_o;
   endproperty
   a_float: assert property (p_float)
      else $error("line driven with enable low");

   property p_polarity;
      @(posedge hclk) disable iff (!hresetn)
      drv_on |=> line_pin_oe && (ls_on_o == $past(tx_f))
                 && (line_pin_o == hs_on_o);
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("switch does not follow tx");

   property p_ot_off;
      @(posedge hclk) disable iff (!hresetn)
      ot_f |=> !line_pin_oe;
   endproperty
   a_ot_off: assert property (p_ot_off)
      else $error("driver on during over-temperature");

   property p_ot_back;
      @(posedge hclk) disable iff (!hresetn)
      $fell(ot_f) && en_f && !ctrl_q[CTRL_DRV_OFF] |=> line_pin_oe;
   endproperty
   a_ot_back: assert property (p_ot_back)
      else $error("driver not restored after cooling");

   property p_wake_set;
      @(posedge hclk) disable iff (!hresetn)
      wake_hit |=> wake_q [*8];
   endproperty
   a_wake_set: assert property (p_wake_set)
      else $error("wake pulse not indicated");

   property p_wake_cause;
      @(posedge hclk) disable iff (!hresetn)
      $rose(wake_q) |-> $past(det.hit) && $past(ctrl_q[CTRL_WAKE_EN]);
   endproperty
   a_wake_cause: assert property (p_wake_cause)
      else $error("wake without valid pulse");

   property p_short_cause;
      @(posedge hclk) disable iff (!hresetn)
      $rose(short_q) |-> $past(det.count, 2) > CNT_W'(SHORT_LONG);
   endproperty
   a_short_cause: assert property (p_short_cause)
      else $error("short flag set too early");

   property p_short_rel;
      @(posedge hclk) disable iff (!hresetn)
      !cur_f |=> !short_flag_oe;
   endproperty
   a_short_rel: assert property (p_short_rel)
      else $error("short flag held after limit ended");

   property p_irq;
      @(posedge hclk) disable iff (!hresetn)
      irq_set[IRQ_WAKE] && mask_q[IRQ_WAKE] && $stable(mask_q) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked wake event gave no interrupt");

   c_wake: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(wake_q));
   c_short: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(short_q));
   c_ot: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(ot_f) ##1 !line_pin_oe);
endmodule
`default_nettype wire

// ---- design/lwfm_pkg.sv ----
`default_nettype none
package lwfm_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int WU_MIN_US     = 45;
   localparam int WU_MAX_US     = 135;
   localparam int SHORT_US      = 80;
   localparam int WAKE_HOLD_US  = 100;
   // least times round up, longest times round down
   localparam int WU_MIN_CYC    = (WU_MIN_US * 1000000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
   localparam int WU_MAX_CYC    = (WU_MAX_US * 1000000) / CLK_PERIOD_PS;
   localparam int SHORT_CYC     = (SHORT_US * 1000000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
   localparam int WAKE_HOLD_CYC = (WAKE_HOLD_US * 1000000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
   localparam int CNT_W         = 16;
   localparam int NSYNC         = 5;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

   localparam int CTRL_WAKE_EN = 0;
   localparam int CTRL_DRV_OFF = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;

   localparam int IRQ_W        = 4;
   localparam int IRQ_WAKE     = 0;
   localparam int IRQ_SHORT    = 1;
   localparam int IRQ_OT_SET   = 2;
   localparam int IRQ_OT_CLR   = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   // synchroniser lanes
   localparam int IN_EN   = 0;
   localparam int IN_TX   = 1;
   localparam int IN_LINE = 2;
   localparam int IN_CUR  = 3;
   localparam int IN_OT   = 4;
endpackage
`default_nettype wire

// ---- design/lwfm_det_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lwfm_det_if;
   import lwfm_pkg::*;
   logic             cond;
   logic             long_q;
   logic             hit;
   logic [CNT_W-1:0] count;
   modport tmr (input cond, output long_q, hit, count);
   modport usr (output cond, input long_q, hit, count);
endinterface
`default_nettype wire

// ---- design/lwfm_pulse_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module lwfm_pulse_timer
   import lwfm_pkg::*;
#(
   parameter int WIN_MIN = WU_MIN_CYC,
   parameter int WIN_MAX = WU_MAX_CYC,
   parameter int LONG    = SHORT_CYC
) (
   input  wire logic hclk,    // system clock
   input  wire logic hresetn, // async reset, low
   lwfm_det_if.tmr   det      // condition in, verdicts out
);
   localparam logic [CNT_W-1:0] MIN_C  = CNT_W'(WIN_MIN);
   localparam logic [CNT_W-1:0] MAX_C  = CNT_W'(WIN_MAX);
   localparam logic [CNT_W-1:0] LONG_C = CNT_W'(LONG);
   localparam logic [CNT_W-1:0] SAT_C  = {CNT_W{1'b1}};

   logic [CNT_W-1:0] cnt_q;
   logic             cond_q;

   // ----------------------------------------------------------------
   // episode length, saturating so a long fault never wraps
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q  <= '0;
         cond_q <= 1'b0;
      end else begin
         cond_q <= det.cond;
         if (!det.cond) begin
            cnt_q <= '0;
         end else if (cnt_q != SAT_C) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // a hit is judged only at the end of an episode: lengths in window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         det.hit    <= 1'b0;
         det.long_q <= 1'b0;
      end else begin
         det.hit    <= cond_q && !det.cond
                       && cnt_q >= MIN_C && cnt_q <= MAX_C;
         det.long_q <= det.cond && cnt_q > LONG_C;
      end
   end

   assign det.count = cnt_q;
endmodule
`default_nettype wire

// ---- tb/lwfm_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// remote master on the line side of the node
// ----------------------------------------------------------------
module lwfm_master_model (
   input  wire logic hclk,        // system clock
   input  wire logic line_pin_o,  // node drive level
   input  wire logic line_pin_oe, // node drives the line
   output var logic  line_pin_i,  // level seen on the line
   output var logic  cur_limit    // node driver held at its limit
);
   logic ovr  = 1'b0;
   logic last = 1'b0;

   // a released line has no keeper: it shows the inverse of the last
   // driven level, so a stale copy cannot pass for a fresh sample
   always @(posedge hclk) begin
      if (line_pin_oe) begin
         last <= line_pin_o;
      end
   end

   // overdriving pushes the line opposite and pins the node at its limit
   assign line_pin_i = (line_pin_oe ? line_pin_o : ~last) ^ ovr;
   assign cur_limit  = ovr;

   task automatic pulse(input int n);
      @(posedge hclk);
      ovr <= 1'b1;
      repeat (n) @(posedge hclk);
      ovr <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin \
   n_tests++; \
   if ((s) !== (e)) begin \
      mismatches++; \
      $display("mismatch %s exp %h got %h", nm, e, s); \
   end \
end
module testbench;
   import lwfm_pkg::*;
   localparam int WMIN = 20;
   localparam int WMAX = 60;
   localparam int SCL  = 40;
   localparam int HOLD = 30;
   typedef struct {int sel; logic [31:0] e;} lwfm_note_s;

   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic        chk_v   = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        en      = 1'b0;
   logic        tx      = 1'b0;
   logic        ot      = 1'b0;
   wire  logic  hreadyout, line_i, cur, lo, loe, ls, hs;
   wire  logic  wake_oe, sf_oe, irq;
   wire  logic  hresp, rx, wake_o, sf_o;
   logic        drv_lvl = 1'b0;
   wire  logic [31:0] hrdata;
   int          mismatches = 0;
   int          n_tests    = 0;
   int          cyc        = 0;
   lwfm_note_s  q[$];
   string       nm[6] = '{"hrdata", "drive", "wake", "short", "irq", "pins"};
   int          lens[5] = '{WMIN-2, WMIN+2, WMAX-2, WMIN+10, WMAX+20};
   logic        wen[5]  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

   always #2.5 hclk = ~hclk;

   lwfm_top #(.WU_MIN(WMIN), .WU_MAX(WMAX), .SHORT_LONG(SCL),
              .WAKE_HOLD(HOLD)) dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
      .hresp, .hrdata, .en_pin_i(en), .tx_pin_i(tx),
      .line_pin_i(line_i), .line_pin_o(lo), .line_pin_oe(loe),
      .ls_on_o(ls), .hs_on_o(hs), .cur_limit_i(cur), .over_temp_i(ot),
      .rx_o(rx), .wake_o, .wake_oe, .short_flag_o(sf_o),
      .short_flag_oe(sf_oe), .irq_o(irq));

   lwfm_master_model mst (.hclk, .line_pin_o(lo), .line_pin_oe(loe),
                          .line_pin_i(line_i), .cur_limit(cur));

   // ----------------------------------------------------------------
   // drivers: every check is noted, the watcher compares it
   // ----------------------------------------------------------------
   task note(input int s, input logic [31:0] e);
      q.push_back('{s, e});
      chk_v <= 1'b1;
   endtask

   task chk_pin(input int s, input logic [31:0] e);
      @(posedge hclk);
      note(s, e);
      @(posedge hclk);
      chk_v <= 1'b0;
   endtask

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] e);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) note(0, e);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      chk_v <= 1'b0;
   endtask

   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watcher and hang guard
   // ----------------------------------------------------------------
   always @(posedge hclk) begin
      lwfm_note_s  n;
      logic [31:0] s;
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         print_verdict();
      end else if (chk_v) begin
         n = q.pop_front();
         case (n.sel)
            0: s = hrdata;
            1: s = {28'h0, ls, hs, loe, lo};
            2: s = {31'h0, wake_oe};
            3: s = {31'h0, sf_oe};
            4: s = {31'h0, irq};
            default: s = {28'h0, hresp, wake_o, sf_o, rx};
         endcase
         `CHK(nm[n.sel], n.e, s)
      end
   end

   initial begin
      void'($urandom(32'h995B));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, OFS_CTRL, 32'h0, 32'h1);
      ahb(1'b0, OFS_IRQ_MASK, 32'h0, 32'h0);
      ahb(1'b1, 8'h10, 32'hFFFFFFFF, 32'h0);
      ahb(1'b0, 8'h10, 32'h0, 32'h0);
      for (int i = 0; i < 24; i++) begin
         logic [2:0] r;
         logic       on;
         logic       ln;
         r = 3'($urandom);
         if (i < 4) r = 3'(i);
         if (i == 20) ahb(1'b1, OFS_CTRL, 32'h3, 32'h0);
         @(posedge hclk);
         {ot, tx, en} <= r;
         on = r[0] & ~r[2] & (i < 20);
         ln = on ? ~r[1] : ~drv_lvl;
         if (on) drv_lvl = ~r[1];
         repeat (8) @(posedge hclk);
         chk_pin(1, {28'h0, on & r[1], on & ~r[1], on,
                     on & ~r[1]});
         chk_pin(5, {31'h0, ln});
         ahb(1'b0, OFS_STATUS, 32'h0,
             {25'h0, r[2], 1'b0, ln, r[1], r[0], 2'h0});
      end
      ahb(1'b1, OFS_CTRL, 32'h1, 32'h0);
      ahb(1'b1, OFS_IRQ_MASK, 32'h1, 32'h0);
      ahb(1'b1, OFS_IRQ_STAT, 32'hF, 32'h0);
      // episode lengths straddle both edges of the wake window
      for (int k = 0; k < 5; k++) begin
         logic w;
         logic sh;
         w = (lens[k] >= WMIN) && (lens[k] <= WMAX) && wen[k];
         sh = (lens[k] > SCL + 2);
         ahb(1'b1, OFS_CTRL, {31'h0, wen[k]}, 32'h0);
         fork
            mst.pulse(lens[k]);
            if (lens[k] > SCL + 12) begin
               repeat (SCL + 12) @(posedge hclk);
               chk_pin(3, 32'h1);
            end
         join
         repeat (8) @(posedge hclk);
         chk_pin(3, 32'h0);
         chk_pin(2, {31'h0, w});
         en <= 1'b0;
         chk_pin(4, {31'h0, w});
         ahb(1'b0, OFS_IRQ_STAT, 32'h0, {30'h0, sh, w});
         ahb(1'b1, OFS_IRQ_STAT, 32'hF, 32'h0);
         chk_pin(4, 32'h0);
         repeat (HOLD + 10) @(posedge hclk);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
